/* File: pkg/pcs_pkg.sv */
package pcs_pkg;

    // configuration field widths
    localparam int LOOP_DIV_W  = 9;
    localparam int POST_DIV_W  = 2;
    localparam int DIAG_SEL_W  = 3;
    localparam int SHIFT_LEN   = DIAG_SEL_W + POST_DIV_W + LOOP_DIV_W;

    // field positions inside the serial shift register
    localparam int SH_LOOP_LSB = 0;
    localparam int SH_POST_LSB = SH_LOOP_LSB + LOOP_DIV_W;
    localparam int SH_DIAG_LSB = SH_POST_LSB + POST_DIV_W;

    // nominal oscillator range, for reference only
    localparam int OSC_MIN_MHZ = 200;
    localparam int OSC_MAX_MHZ = 400;
    localparam int MCLK_MHZ    = 20;

    // values after reset: parallel pins idle high, serial pins idle low
    localparam logic [LOOP_DIV_W-1:0] LOOP_DIV_RST = 9'h1ff;
    localparam logic [POST_DIV_W-1:0] POST_DIV_RST = 2'h3;
    localparam logic [DIAG_SEL_W-1:0] DIAG_SEL_RST = 3'h0;
    localparam logic [SHIFT_LEN-1:0]  SHIFT_RST    = 14'h0000;

    // post-divide patterns
    localparam logic [POST_DIV_W-1:0] POST_DIV_1 = 2'h0;
    localparam logic [POST_DIV_W-1:0] POST_DIV_2 = 2'h1;
    localparam logic [POST_DIV_W-1:0] POST_DIV_4 = 2'h2;
    localparam logic [POST_DIV_W-1:0] POST_DIV_8 = 2'h3;

    // width of the half-period counter, sized for the largest ratio (divide by 8)
    localparam int HALF_CNT_W = 3;

    // diagnostic output selections
    typedef enum logic [DIAG_SEL_W-1:0] {
        DIAG_SHIFT_MSB = 3'h0,
        DIAG_HIGH      = 3'h1,
        DIAG_LOW       = 3'h2,
        DIAG_LOOP_FB   = 3'h3,
        DIAG_POST_RAW  = 3'h4
    } pcs_diag_t;

endpackage

/* File: pkg/pcs_div_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pcs_div_if;
    import pcs_pkg::*;
    logic [POST_DIV_W-1:0] post_div; // latched post-divide field
    logic                  out_en;   // synchronised output enable request
    logic                  fout;     // gated output, true phase
    logic                  fout_b;   // gated output, complement
    logic                  raw;      // ungated divider phase

    modport ctrl (output post_div, output out_en,
                  input fout, input fout_b, input raw);
    modport div  (input post_div, input out_en,
                  output fout, output fout_b, output raw);
endinterface
`default_nettype wire

/* File: core/pcs_out_div.sv */
`timescale 1ns/1ps
`default_nettype none
module pcs_out_div
    import pcs_pkg::*;
(
    input  wire logic MCLK,  // stand-in for the oscillator clock
    input  wire logic RST_B, // synchronous reset, active low
    pcs_div_if.div    dv     // divider control and outputs
);

    logic [HALF_CNT_W-1:0] cnt_reg;    // cycles into the current half
    logic [HALF_CNT_W-1:0] cnt_next;
    logic [HALF_CNT_W-1:0] half_last;  // last count of a half period
    logic                  ph_reg;     // free-running divider phase
    logic                  ph_next;
    logic                  en_reg;     // enable applied to the output
    logic                  en_next;
    logic                  fout_reg;
    logic                  fout_next;
    logic                  fout_b_reg;
    logic                  fout_b_next;

    ////////////////////////////////////////////////////////////////////
    // half period lengths: 1, 2, 4 or 8 clocks
    always_comb begin
        unique case (dv.post_div)
            POST_DIV_1: half_last = 3'h0;
            POST_DIV_2: half_last = 3'h1;
            POST_DIV_4: half_last = 3'h3;
            POST_DIV_8: half_last = 3'h7;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // divider and enable gating
    always_comb begin
        cnt_next = cnt_reg + 3'h1;
        ph_next  = ph_reg;
        en_next  = en_reg;
        // >= so that a shorter ratio loaded mid-half ends it at once
        if (cnt_reg >= half_last) begin
            cnt_next = 3'h0;
            ph_next  = ~ph_reg;
            // enable only changes when a full period has ended
            if (ph_reg) begin
                en_next = dv.out_en;
            end
        end
        // disabled output rests low, never cutting a high half short
        fout_next   = en_next & ph_next;
        fout_b_next = ~fout_next;
    end

    // register stage only
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            cnt_reg    <= 3'h0;
            ph_reg     <= 1'b0;
            en_reg     <= 1'b0;
            fout_reg   <= 1'b0;
            fout_b_reg <= 1'b1;
        end else begin
            cnt_reg    <= cnt_next;
            ph_reg     <= ph_next;
            en_reg     <= en_next;
            fout_reg   <= fout_next;
            fout_b_reg <= fout_b_next;
        end
    end

    assign dv.fout   = fout_reg;
    assign dv.fout_b = fout_b_reg;
    assign dv.raw    = ph_reg;

endmodule
`default_nettype wire

/* File: core/pcs_config_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - serial and parallel paths load same latches
// - output is oscillator through post-divider
// - post-divide 00/01/10/11 gives 1/2/4/8
// - serial data shifts on shift clock rise
// - serial latch transparent high, holds from fall
// - parallel latch transparent low, captures on rise
// - loop divide from parallel pins, bit 8 MSB
// - post-divide also from parallel pins
// - output enable active high
// - enable changes synchronised to output clock
// - diagnostic select, serial only, picks diag pin
// - open serial pins low, parallel pins high
module pcs_config_top
    import pcs_pkg::*;
(
    input  wire logic                  MCLK,         // 20 MHz clock
    input  wire logic                  RST_B,        // sync reset, low
    input  wire logic                  SER_CLK,      // serial shift clock
    input  wire logic                  SER_DATA,     // serial data
    input  wire logic                  SER_LOAD,     // serial latch strobe
    input  wire logic                  PAR_LOAD_B,   // parallel strobe
    input  wire logic [LOOP_DIV_W-1:0] LOOP_DIV_IN,  // parallel loop div
    input  wire logic [POST_DIV_W-1:0] POST_DIV_IN,  // parallel post div
    input  wire logic                  OUT_EN,       // output enable
    output var  logic                  FOUT,         // synth output
    output var  logic                  FOUT_B,       // synth complement
    output var  logic                  DIAG_OUT,     // diagnostic pin
    output var  logic [LOOP_DIV_W-1:0] CFG_LOOP_DIV, // latched loop div
    output var  logic [POST_DIV_W-1:0] CFG_POST_DIV, // latched post div
    output var  logic [DIAG_SEL_W-1:0] CFG_DIAG_SEL  // latched diag sel
);

    // width of the bundle of pins that pass the synchroniser
    localparam int SYNC_W = 4 + 1 + POST_DIV_W + LOOP_DIV_W;
    // idle levels of an open pin: serial low, parallel high
    localparam logic [SYNC_W-1:0] SYNC_RST = 16'h1fff;

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser, two stages
    logic [SYNC_W-1:0] meta_reg;  // first stage, read by sync only
    logic [SYNC_W-1:0] sync_reg;  // second stage, safe to use
    logic              sclk_d_reg; // previous shift clock level
    logic              sclk_d_next;

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            meta_reg <= SYNC_RST;
            sync_reg <= SYNC_RST;
        end else begin
            meta_reg <= {SER_CLK, SER_DATA, SER_LOAD, PAR_LOAD_B, OUT_EN,
                         POST_DIV_IN, LOOP_DIV_IN};
            sync_reg <= meta_reg;
        end
    end

    // named views of the synchronised pins
    logic                  s_clk;
    logic                  s_data;
    logic                  s_load;
    logic                  p_load_b;
    logic                  s_oe;
    logic [POST_DIV_W-1:0] p_post;
    logic [LOOP_DIV_W-1:0] p_loop;

    assign {s_clk, s_data, s_load, p_load_b, s_oe, p_post, p_loop} =
        sync_reg;

    ////////////////////////////////////////////////////////////////////
    // serial shift register
    logic [SHIFT_LEN-1:0] shift_reg;  // first bit in ends at the top
    logic [SHIFT_LEN-1:0] shift_next;

    always_comb begin
        sclk_d_next = s_clk;
        shift_next  = shift_reg;
        // rising edge of the shift clock seen in the clock domain;
        // the shift clock must stay well below MCLK/4 for this
        if (s_clk && !sclk_d_reg) begin
            shift_next = {shift_reg[SHIFT_LEN-2:0], s_data};
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            shift_reg  <= SHIFT_RST;
            sclk_d_reg <= 1'b0;
        end else begin
            shift_reg  <= shift_next;
            sclk_d_reg <= sclk_d_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration latches, shared by both load paths
    logic [LOOP_DIV_W-1:0] loop_reg;
    logic [LOOP_DIV_W-1:0] loop_next;
    logic [POST_DIV_W-1:0] post_reg;
    logic [POST_DIV_W-1:0] post_next;
    logic [DIAG_SEL_W-1:0] diag_reg;
    logic [DIAG_SEL_W-1:0] diag_next;

    always_comb begin
        loop_next = loop_reg;
        post_next = post_reg;
        diag_next = diag_reg;
        // serial strobe high: follow the shift register
        if (s_load) begin
            loop_next = shift_reg[SH_LOOP_LSB +: LOOP_DIV_W];
            post_next = shift_reg[SH_POST_LSB +: POST_DIV_W];
            diag_next = shift_reg[SH_DIAG_LSB +: DIAG_SEL_W];
        end
        // parallel strobe low: follow the pins; wins over serial when
        // both are open, and never touches the diagnostic field
        if (!p_load_b) begin
            loop_next = p_loop;
            post_next = p_post;
        end
    end

    // strobes closing freeze the last followed value: hold
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            loop_reg <= LOOP_DIV_RST;
            post_reg <= POST_DIV_RST;
            diag_reg <= DIAG_SEL_RST;
        end else begin
            loop_reg <= loop_next;
            post_reg <= post_next;
            diag_reg <= diag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // loop divider model: toggles a feedback phase every loop_reg+1
    logic [LOOP_DIV_W-1:0] fb_cnt_reg;
    logic [LOOP_DIV_W-1:0] fb_cnt_next;
    logic                  fb_reg;
    logic                  fb_next;

    always_comb begin
        fb_cnt_next = fb_cnt_reg + 9'h001;
        fb_next     = fb_reg;
        if (fb_cnt_reg >= loop_reg) begin
            fb_cnt_next = 9'h000;
            fb_next     = ~fb_reg;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            fb_cnt_reg <= 9'h000;
            fb_reg     <= 1'b0;
        end else begin
            fb_cnt_reg <= fb_cnt_next;
            fb_reg     <= fb_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // post-divider and synchronous enable
    pcs_div_if dif ();

    assign dif.post_div = post_reg;
    assign dif.out_en   = s_oe;

    pcs_out_div u_div (
        .MCLK  (MCLK),
        .RST_B (RST_B),
        .dv    (dif.div)
    );

    ////////////////////////////////////////////////////////////////////
    // diagnostic pin
    logic diag_out_reg;
    logic diag_out_next;

    always_comb begin
        unique case (diag_reg)
            DIAG_SHIFT_MSB: diag_out_next = shift_reg[SHIFT_LEN-1];
            DIAG_HIGH:      diag_out_next = 1'b1;
            DIAG_LOW:       diag_out_next = 1'b0;
            DIAG_LOOP_FB:   diag_out_next = fb_reg;
            DIAG_POST_RAW:  diag_out_next = dif.raw;
            default:        diag_out_next = 1'b0; // spare codes
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            diag_out_reg <= 1'b0;
        end else begin
            diag_out_reg <= diag_out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flip-flop
    assign FOUT         = dif.fout;
    assign FOUT_B       = dif.fout_b;
    assign DIAG_OUT     = diag_out_reg;
    assign CFG_LOOP_DIV = loop_reg;
    assign CFG_POST_DIV = post_reg;
    assign CFG_DIAG_SEL = diag_reg;

endmodule
`default_nettype wire

/* File: test/pcs_config_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pcs_config_checker
    import pcs_pkg::*;
(
    input wire logic                  MCLK,         // clock
    input wire logic                  RST_B,        // reset, low
    input wire logic                  SER_LOAD,     // serial strobe
    input wire logic                  PAR_LOAD_B,   // parallel strobe
    input wire logic [LOOP_DIV_W-1:0] LOOP_DIV_IN,  // loop pins
    input wire logic [POST_DIV_W-1:0] POST_DIV_IN,  // post pins
    input wire logic                  OUT_EN,       // enable
    input wire logic                  FOUT,         // output
    input wire logic                  FOUT_B,       // complement
    input wire logic                  DIAG_OUT,     // diag pin
    input wire logic [LOOP_DIV_W-1:0] CFG_LOOP_DIV, // loop latch
    input wire logic [POST_DIV_W-1:0] CFG_POST_DIV, // post latch
    input wire logic [DIAG_SEL_W-1:0] CFG_DIAG_SEL  // diag latch
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////////
    // cycles of enable low; saturates so a long disable never wraps
    logic [5:0] off_cnt_reg;  // low-enable count
    logic [5:0] off_cnt_next; // its next value
    always_comb begin
        off_cnt_next = off_cnt_reg;
        if (OUT_EN) off_cnt_next = 6'h00;
        else if (off_cnt_reg != 6'h28) off_cnt_next = off_cnt_reg + 6'h01;
    end
    always_ff @(posedge MCLK) off_cnt_reg <= RST_B ? off_cnt_next : 6'h00;
    ////////////////////////////////////////////////////////////////////
    chk_reset_vals: assert property (disable iff (1'b0) !RST_B |=>
        CFG_LOOP_DIV == 9'h1ff && CFG_POST_DIV == 2'h3 && !FOUT && FOUT_B
        && CFG_DIAG_SEL == 3'h0) else $error("reset values wrong");
    chk_fout_pair: assert property (FOUT_B == !FOUT)
        else $error("outputs not complementary");
    chk_par_take: assert property ((!PAR_LOAD_B && $stable(LOOP_DIV_IN)
        && $stable(POST_DIV_IN))[*4] |=> CFG_LOOP_DIV == $past(LOOP_DIV_IN)
        && CFG_POST_DIV == $past(POST_DIV_IN)) else $error("load lost");
    chk_par_hold: assert property ((PAR_LOAD_B && !SER_LOAD)[*5] |=>
        $stable(CFG_LOOP_DIV) && $stable(CFG_POST_DIV))
        else $error("closed latch moved");
    chk_diag_serial: assert property ((!SER_LOAD)[*5] |=>
        $stable(CFG_DIAG_SEL)) else $error("diag select moved");
    chk_diag_high: assert property ((CFG_DIAG_SEL == 3'h1)[*2] |=>
        DIAG_OUT) else $error("diag not high");
    chk_diag_low: assert property ((CFG_DIAG_SEL == 3'h2
        || CFG_DIAG_SEL > 3'h4)[*2] |=> !DIAG_OUT) else $error("diag not low");
    chk_off_static: assert property (off_cnt_reg == 6'h28 |->
        !FOUT && FOUT_B) else $error("output runs while disabled");
    chk_half_two: assert property ($rose(FOUT) && CFG_POST_DIV == 2'h1
        && $past(CFG_POST_DIV, 2) == 2'h1 ##1 (CFG_POST_DIV == 2'h1)[*2]
        |-> $past(FOUT) && !FOUT) else $error("high half not two cycles");
    cov_ser_load: cover property ($fell(SER_LOAD));
    cov_par_load: cover property ($rose(PAR_LOAD_B));
    cov_div8: cover property ($rose(FOUT) && CFG_POST_DIV == 2'h3);
    cov_off: cover property (off_cnt_reg == 6'h28);
endmodule
bind pcs_config_top pcs_config_checker u_chk (.MCLK, .RST_B, .SER_LOAD,
    .PAR_LOAD_B, .LOOP_DIV_IN, .POST_DIV_IN, .OUT_EN, .FOUT, .FOUT_B,
    .DIAG_OUT, .CFG_LOOP_DIV, .CFG_POST_DIV, .CFG_DIAG_SEL);
`default_nettype wire

/* File: test/pcs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model
    import pcs_pkg::*;
(
    input  wire logic                  MCLK,        // bench clock
    output var  logic                  SER_CLK,     // shift clock
    output var  logic                  SER_DATA,    // serial data
    output var  logic                  SER_LOAD,    // serial strobe
    output var  logic                  PAR_LOAD_B,  // parallel strobe
    output var  logic [LOOP_DIV_W-1:0] LOOP_DIV_IN, // loop pins
    output var  logic [POST_DIV_W-1:0] POST_DIV_IN  // post pins
);
    // idle levels of open pins: serial low, parallel high
    initial begin
        {SER_CLK, SER_DATA, SER_LOAD} = 3'h0;
        {PAR_LOAD_B, LOOP_DIV_IN, POST_DIV_IN} = 12'hfff;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge MCLK);
    endtask
    // msb first; levels held 3 clocks so synchronisers never miss one
    task automatic shift_word(input logic [SHIFT_LEN-1:0] w);
        for (int i = SHIFT_LEN - 1; i >= 0; i--) begin
            wait_n(1);
            SER_DATA <= w[i];
            wait_n(3);
            SER_CLK <= 1'b1;
            wait_n(3);
            SER_CLK <= 1'b0;
        end
        wait_n(3);
        SER_DATA <= 1'b0; // released, pulldown wins
    endtask
    // no shift clock here, so the shift data stays put across the fall
    task automatic ser_latch();
        wait_n(1);
        SER_LOAD <= 1'b1;
        wait_n(6);
        SER_LOAD <= 1'b0;
        wait_n(6);
    endtask
    // pins stable well before and after the rise, then released high
    task automatic par_load(input logic [8:0] lp, input logic [1:0] pd);
        wait_n(1);
        LOOP_DIV_IN <= lp;
        POST_DIV_IN <= pd;
        PAR_LOAD_B <= 1'b0;
        wait_n(6);
        PAR_LOAD_B <= 1'b1;
        wait_n(4);
        {LOOP_DIV_IN, POST_DIV_IN} <= 11'h7ff;
        wait_n(4);
    endtask
endmodule
`default_nettype wire

/* File: test/pcs_config_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pcs_config_top_tb;
    import pcs_pkg::*;
    logic MCLK = 1'b0, RST_B = 1'b0, OUT_EN = 1'b1; // driven here
    logic SER_CLK, SER_DATA, SER_LOAD, PAR_LOAD_B;  // from host model
    logic FOUT, FOUT_B, DIAG_OUT;                   // dut outputs
    logic [8:0] LOOP_DIV_IN, CFG_LOOP_DIV;          // loop divide
    logic [1:0] POST_DIV_IN, CFG_POST_DIV;          // post divide
    logic [2:0] CFG_DIAG_SEL;                       // diag select
    logic [13:0] w;                                 // serial word
    int n_errors = 0, check_count = 0, cyc = 0, per, hi;
    int m_loop = 511, m_post = 3, m_diag = 0, m_sh = 0; // bench model
    always #25 MCLK = ~MCLK;
    pcs_host_model host (.MCLK, .SER_CLK, .SER_DATA, .SER_LOAD, .PAR_LOAD_B,
        .LOOP_DIV_IN, .POST_DIV_IN);
    pcs_config_top dut (.MCLK, .RST_B, .SER_CLK, .SER_DATA, .SER_LOAD,
        .PAR_LOAD_B, .LOOP_DIV_IN, .POST_DIV_IN, .OUT_EN, .FOUT, .FOUT_B,
        .DIAG_OUT, .CFG_LOOP_DIV, .CFG_POST_DIV, .CFG_DIAG_SEL);
    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard: whole run needs well under this
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic cmp_cfg();
        @(negedge MCLK);
        check_count++;
        if (CFG_LOOP_DIV !== 9'(m_loop) || CFG_POST_DIV !== 2'(m_post)
            || CFG_DIAG_SEL !== 3'(m_diag)) begin
            n_errors++;
            $display("mismatch cfg expected %h %h %h seen %h %h %h", m_loop,
                m_post, m_diag, CFG_LOOP_DIV, CFG_POST_DIV, CFG_DIAG_SEL);
        end
    endtask
    task automatic cmp_val(string nm, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // model shift register follows every bit; latch copies its fields
    task automatic ser_send(input logic [13:0] v, input bit ld);
        host.shift_word(v);
        for (int i = 13; i >= 0; i--) m_sh = ((m_sh << 1) | v[i]) & 'h3fff;
        if (ld) begin
            host.ser_latch();
            {m_loop, m_post, m_diag} =
                {m_sh & 511, (m_sh >> 9) & 3, m_sh >> 11};
        end
    endtask
    // rise-to-rise time of the third rise; earlier ones may be shortened
    task automatic measure(output int p);
        int t0, n;
        logic prev;
        {t0, n, p, prev} = {32'h0, 32'h0, 32'h0, FOUT};
        for (int i = 0; i < 80 && n < 3; i++) begin
            @(negedge MCLK);
            if (FOUT === 1'b1 && prev === 1'b0) begin
                n++;
                if (n == 3) p = i - t0;
                t0 = i;
            end
            prev = FOUT;
        end
    endtask
    // cycles between the second and third change of the diag pin;
    // the first change may come from a half cut short by the load
    task automatic diag_half(output int h);
        int t0, n;
        logic prev;
        {t0, n, h, prev} = {32'h0, 32'h0, 32'h0, DIAG_OUT};
        for (int i = 0; i < 1700 && n < 3; i++) begin
            @(negedge MCLK);
            if (DIAG_OUT !== prev) begin
                n++;
                if (n == 3) h = i - t0;
                t0 = i;
            end
            prev = DIAG_OUT;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h0000_015b));
        repeat (20) @(posedge MCLK);
        RST_B <= 1'b1;
        cmp_cfg();
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            m_loop = $urandom_range(511, 0);
            m_post = p;
            host.par_load(9'(m_loop), 2'(p));
            cmp_cfg();
            measure(per);
            cmp_val("fout_period", 16'(2 << p), 16'(per));
        end
        $display("test parallel done");
        @(posedge MCLK) OUT_EN <= 1'b0;
        repeat (44) @(negedge MCLK);
        cmp_val("fout_off", 16'h0001, {14'h0000, FOUT, FOUT_B});
        @(posedge MCLK) OUT_EN <= 1'b1;
        for (int i = 0; i < 80 && FOUT !== 1'b1; i++) @(negedge MCLK);
        hi = 0;
        while (FOUT === 1'b1 && hi < 20) begin
            @(negedge MCLK);
            hi++;
        end
        cmp_val("first_high", 16'(1 << m_post), 16'(hi));
        $display("test enable done");
        for (int d = 7; d >= 0; d--) begin
            w = {d[2:0], 11'($urandom)};
            ser_send(w, 1'b1);
            cmp_cfg();
            if (d == 3 || d == 4) begin
                // feedback halves last loop+1 clocks, raw halves 1 << post
                per = (d == 3) ? m_loop + 1 : 1 << m_post;
                diag_half(hi);
                cmp_val("diag_half", 16'(per), 16'(hi));
            end else begin
                cmp_val("diag_out", 16'(d == 1), 16'(DIAG_OUT));
            end
        end
        ser_send({3'h4, 11'($urandom)}, 1'b0);
        cmp_cfg();
        cmp_val("diag_msb", 16'h0001, 16'(DIAG_OUT));
        $display("test serial done");
        conclude();
    end
endmodule
`default_nettype wire
